// ### core/i2c_slave_host_if.sv
/*
 Two-wire slave host interface. The bus engine runs on link_clk, an
 oversampling clock that samples SCL and SDA; register requests are
 handed to the clk domain by toggle handshakes. Assumes an external
 open-drain pad joins sda_out/sda_oe with sda_in, that SCL is an input
 only, and that the register file answers rd_data one clk after
 reg_req.rd.
*/
// Notes on behaviour
// - Slave only; never drives SCL, no arbitration.
// - Standard, Fast and High-speed bus rates.
// - SDA only pulled low or released.
// - Spike filter on SCL and SDA inputs.
// - SDA changes only while SCL is low.
// - Detect START and STOP while SCL high.
// - Repeated START restarts address; busy until STOP.
// - MSB first bytes, each with acknowledge.
// - Receiver pulls SDA low during ack pulse.
// - Master NACK ends read; device releases SDA.
// - First byte compared to seven-bit address.
// - Select low: address 0101b plus three straps.
// - Select high: six straps, bit six zero.
// - Straps latched once at reset release.
// - Write: register byte, then data, same register.
// - Reads always return the same register.
// - Master code switches filter to high speed.
// - High speed holds across Sr, ends at STOP.
// - Force bit keeps high speed while it is set.
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"

module i2c_slave_host_if
	import i2c_slave_pkg::*;
#(
	parameter int FILT_FS = `FILT_FS_CYC,
	parameter int FILT_HS = `FILT_HS_CYC
) (
	// Core clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link sampling clock
	input wire logic link_clk,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Address straps
	input wire logic address_select_pin,
	input wire logic [5:0] adr_pins,
	// Mode control and status
	input wire logic force_high_speed_bit,
	output logic high_speed_mode,
	// Register access
	output reg_req_type reg_req,
	input wire logic [7:0] rd_data
);

	if (FILT_FS < 1 || FILT_FS > 15 || FILT_HS < 1 || FILT_HS > 15) begin
		$error("filter lengths must lie in 1..15");
	end

	// Link-domain reset, synchronised from the core reset
	logic lrst_s1, lrst_r;
	always_ff @(posedge link_clk) begin
		lrst_s1 <= reset;
		lrst_r <= lrst_s1;
	end

	// Pin synchronisers and spike filters
	bus_in_type raw_s1, raw_s2, filt_r, filt_d_r;
	logic hs_eff;
	logic [3:0] filt_len;
	assign filt_len = hs_eff ? 4'(FILT_HS) : 4'(FILT_FS);

	always_ff @(posedge link_clk) begin
		raw_s1 <= '{scl: scl_in, sda: sda_in};
		raw_s2 <= raw_s1;
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_filt
			logic [3:0] cnt_r;
			always_ff @(posedge link_clk) begin
				if (lrst_r) begin
					cnt_r <= 4'h0;
					filt_r[g] <= 1'b1;
				end else if (raw_s2[g] == filt_r[g]) begin
					cnt_r <= 4'h0;
				end else if (cnt_r + 4'h1 >= filt_len) begin
					cnt_r <= 4'h0;
					filt_r[g] <= raw_s2[g];
				end else begin
					cnt_r <= cnt_r + 4'h1;
				end
			end
		end
	endgenerate

	always_ff @(posedge link_clk) begin
		if (lrst_r)
			filt_d_r <= '1;
		else
			filt_d_r <= filt_r;
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = filt_r.scl & ~filt_d_r.scl;
	assign scl_fall = ~filt_r.scl & filt_d_r.scl;
	// SDA moving while SCL stays high marks a condition
	assign start_det = filt_r.scl & filt_d_r.scl
		& filt_d_r.sda & ~filt_r.sda;
	assign stop_det = filt_r.scl & filt_d_r.scl
		& ~filt_d_r.sda & filt_r.sda;

	// Strap capture, once after reset release
	logic [6:0] strap_s1, strap_s2, slave_addr_r;
	logic strap_done_r;
	always_ff @(posedge link_clk) begin
		strap_s1 <= {address_select_pin, adr_pins};
		strap_s2 <= strap_s1;
	end

	always_ff @(posedge link_clk) begin
		if (lrst_r) begin
			strap_done_r <= 1'b0;
			slave_addr_r <= 7'h00;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			if (strap_s2[6])
				slave_addr_r <= {1'b0, strap_s2[5:0]};
			else
				slave_addr_r <= {`ADDR_FIXED_HI, strap_s2[2:0]};
		end
	end

	// Force bit comes from the core domain
	logic force_s1, force_s2;
	always_ff @(posedge link_clk) begin
		force_s1 <= force_high_speed_bit;
		force_s2 <= force_s1;
	end

	// Read-done toggle back from the core domain
	logic rdone_s1, rdone_s2, rdone_s3, rd_done_tgl_r;
	logic [7:0] rd_hold_r, rd_buf_r;
	always_ff @(posedge link_clk) begin
		rdone_s1 <= rd_done_tgl_r;
		rdone_s2 <= rdone_s1;
		rdone_s3 <= rdone_s2;
	end

	always_ff @(posedge link_clk) begin
		if (lrst_r)
			rd_buf_r <= 8'h00;
		else if (rdone_s2 ^ rdone_s3)
			rd_buf_r <= rd_hold_r;
	end

	// Bus engine
	state_type state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shreg_r, reg_addr_r, wr_buf_r;
	logic rw_r, want_reg_r, hs_r, sda_oe_r, sda_out_r;
	logic wr_tgl_r, rd_tgl_r;
	assign hs_eff = hs_r | force_s2;

	always_ff @(posedge link_clk) begin
		if (lrst_r) begin
			state_r <= st_idle;
			bit_cnt_r <= 4'h0;
			shreg_r <= 8'h00;
			reg_addr_r <= 8'h00;
			wr_buf_r <= 8'h00;
			rw_r <= 1'b0;
			want_reg_r <= 1'b0;
			hs_r <= 1'b0;
			sda_oe_r <= 1'b0;
			wr_tgl_r <= 1'b0;
			rd_tgl_r <= 1'b0;
		end else if (stop_det) begin
			state_r <= st_idle;
			sda_oe_r <= 1'b0;
			hs_r <= 1'b0;
		end else if (start_det) begin
			state_r <= st_addr;
			bit_cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end else begin
			unique case (state_r)
			st_idle: begin
				sda_oe_r <= 1'b0;
			end
			st_addr: begin
				if (scl_rise) begin
					shreg_r <= {shreg_r[6:0], filt_r.sda};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end else if (scl_fall && bit_cnt_r == `BYTE_BITS) begin
					if (shreg_r[7:`MCODE_POS] == `MCODE_HI) begin
						hs_r <= 1'b1;
						state_r <= st_idle;
					end else if (shreg_r[7:1] == slave_addr_r) begin
						rw_r <= shreg_r[0];
						want_reg_r <= ~shreg_r[0];
						sda_oe_r <= 1'b1;
						state_r <= st_ack_out;
						if (shreg_r[0])
							rd_tgl_r <= ~rd_tgl_r;
					end else begin
						state_r <= st_idle;
					end
				end
			end
			st_ack_out: begin
				if (scl_fall) begin
					bit_cnt_r <= 4'h0;
					if (rw_r) begin
						shreg_r <= rd_buf_r;
						sda_oe_r <= ~rd_buf_r[7];
						state_r <= st_tx;
					end else begin
						sda_oe_r <= 1'b0;
						state_r <= st_rx;
					end
				end
			end
			st_rx: begin
				if (scl_rise) begin
					shreg_r <= {shreg_r[6:0], filt_r.sda};
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end else if (scl_fall && bit_cnt_r == `BYTE_BITS) begin
					if (want_reg_r) begin
						reg_addr_r <= shreg_r;
						want_reg_r <= 1'b0;
					end else begin
						wr_buf_r <= shreg_r;
						wr_tgl_r <= ~wr_tgl_r;
					end
					sda_oe_r <= 1'b1;
					state_r <= st_ack_out;
				end
			end
			st_tx: begin
				if (scl_fall) begin
					if (bit_cnt_r == `LAST_TX_BIT) begin
						sda_oe_r <= 1'b0;
						state_r <= st_ack_in;
					end else begin
						shreg_r <= {shreg_r[6:0], 1'b0};
						sda_oe_r <= ~shreg_r[6];
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
			end
			st_ack_in: begin
				if (scl_rise) begin
					if (filt_r.sda)
						state_r <= st_idle;
					else
						rd_tgl_r <= ~rd_tgl_r;
				end else if (scl_fall) begin
					bit_cnt_r <= 4'h0;
					shreg_r <= rd_buf_r;
					sda_oe_r <= ~rd_buf_r[7];
					state_r <= st_tx;
				end
			end
			endcase
		end
	end

	// Pad only ever pulls low; SCL is never driven
	always_ff @(posedge link_clk) begin
		sda_out_r <= 1'b0;
	end
	assign sda_out = sda_out_r;
	assign sda_oe = sda_oe_r;

	// Core domain: request handshakes and mode status
	logic wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3;
	logic hs_s1, hs_s2, rd_pend_r;
	reg_req_type req_r;
	always_ff @(posedge clk) begin
		wr_s1 <= wr_tgl_r;
		wr_s2 <= wr_s1;
		wr_s3 <= wr_s2;
		rd_s1 <= rd_tgl_r;
		rd_s2 <= rd_s1;
		rd_s3 <= rd_s2;
		hs_s1 <= hs_eff;
		hs_s2 <= hs_s1;
	end

	// Address is stable before each toggle; write data is loaded with it
	always_ff @(posedge clk) begin
		if (reset) begin
			req_r <= '0;
		end else begin
			req_r.wr <= wr_s2 ^ wr_s3;
			req_r.rd <= rd_s2 ^ rd_s3;
			if ((wr_s2 ^ wr_s3) || (rd_s2 ^ rd_s3))
				req_r.addr <= reg_addr_r;
			if (wr_s2 ^ wr_s3)
				req_r.data <= wr_buf_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_pend_r <= 1'b0;
			rd_hold_r <= 8'h00;
			rd_done_tgl_r <= 1'b0;
		end else begin
			rd_pend_r <= req_r.rd;
			if (rd_pend_r) begin
				rd_hold_r <= rd_data;
				rd_done_tgl_r <= ~rd_done_tgl_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			high_speed_mode <= 1'b0;
		else
			high_speed_mode <= hs_s2;
	end
	assign reg_req = req_r;

endmodule

// ### core/i2c_slave_consts.svh
/*
 Fixed values for the two-wire slave host interface: address strap
 layout, master code pattern, bus rates and spike suppression times.
 Assumes it is included by the slave module only.
*/
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

// Upper address nibble when the address-select pin is low
`define ADDR_FIXED_HI 4'h5
// Master code pattern 00001XXXb, upper five bits
`define MCODE_HI 5'h01
`define MCODE_POS 3
// Bus rates in bit per second
`define RATE_STD_BPS 100000
`define RATE_FAST_BPS 400000
`define RATE_HS_BPS 3400000
// Link sampling clock period and spike widths, in ps
`define LINK_PERIOD_PS 32000
`define SPIKE_FS_PS 50000
`define SPIKE_HS_PS 10000
// Least filter lengths, rounded up to whole link cycles
`define FILT_FS_CYC \
	((`SPIKE_FS_PS + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS)
`define FILT_HS_CYC \
	((`SPIKE_HS_PS + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS)
// Bits per byte and index of the last sent bit before the ack slot
`define BYTE_BITS 4'h8
`define LAST_TX_BIT 4'h7

`endif

// ### core/i2c_slave_pkg.sv
/*
 Types shared by the two-wire slave host interface.
 Assumes the constants header sits beside it.
*/
package i2c_slave_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_ack_out,
		st_rx,
		st_tx,
		st_ack_in
	} state_type;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_in_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_type;

endpackage

// ### test/i2c_slave_host_props.sv
/*
 Port checker for the two-wire slave host interface.
 Assumes it is bound to the slave module with both clocks running.
*/
`timescale 1ns/1ps
module i2c_slave_host_props
	import i2c_slave_pkg::*;
(
	// Clocks and reset
	input wire logic clk,
	input wire logic link_clk,
	input wire logic reset,
	// Bus side
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Core side
	input wire logic force_high_speed_bit,
	input wire logic high_speed_mode,
	input wire reg_req_type reg_req
);
	a_oe_scl_low: assert property (
		@(posedge link_clk) disable iff (reset)
		$changed(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
	a_ack_span: assert property (
		@(posedge link_clk) disable iff (reset)
		$rose(sda_oe) |=> sda_oe [*4]) else $error("drive too short");
	a_drive_low: assert property (
		@(posedge link_clk) disable iff (reset)
		sda_oe |-> !sda_out) else $error("sda driven high");
	a_hs_stop: assert property (
		@(posedge link_clk) disable iff (reset)
		$fell(high_speed_mode) |-> scl_in && sda_in)
		else $error("hs left mid frame");
	a_force_hs: assert property (
		@(posedge clk) disable iff (reset)
		force_high_speed_bit |-> ##[0:8] high_speed_mode)
		else $error("force ignored");
	a_wr_once: assert property (
		@(posedge clk) disable iff (reset)
		reg_req.wr |=> !reg_req.wr [*8]) else $error("write repeated");
	a_rd_once: assert property (
		@(posedge clk) disable iff (reset)
		reg_req.rd |=> !reg_req.rd [*8]) else $error("read repeated");
	a_req_excl: assert property (
		@(posedge clk) disable iff (reset)
		!(reg_req.wr && reg_req.rd)) else $error("wr and rd together");
endmodule
bind i2c_slave_host_if i2c_slave_host_props chk (.clk(clk),
	.link_clk(link_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe),
	.force_high_speed_bit(force_high_speed_bit),
	.high_speed_mode(high_speed_mode), .reg_req(reg_req));

// ### test/i2c_master_model.sv
/*
 Behavioural bus master for the slave host interface bench.
 Assumes a pull-up on the shared data line outside.
*/
`timescale 1ns/1ps
module i2c_master_model #(
	parameter int Q = 625
) (
	// Bus lines
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Entered with scl low this is a repeated start
	task automatic start();
		sda_m = 1'b1;
		#Q scl = 1'b1;
		#Q sda_m = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic stop();
		sda_m = 1'b0;
		#Q scl = 1'b1;
		#Q sda_m = 1'b1;
		#Q;
	endtask
	// Ack slot: mack high releases the line
	task automatic xfer(input logic [7:0] d, input logic mack,
		output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_m = (i == 0) ? mack : d[i-1];
			#Q scl = 1'b1;
			#Q;
			if (i == 0)
				ack = sda;
			else
				q[i-1] = sda;
			#Q scl = 1'b0;
			#Q;
		end
	endtask
endmodule

// ### test/tb_i2c_slave_host_interface.sv
/*
 Self-checking bench for the two-wire slave host interface.
 Assumes the master model and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_i2c_slave_host_interface;
	import i2c_slave_pkg::*;
	localparam logic [6:0] A0 = 7'h2A;
	logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, sel = 1'b0;
	logic frc = 1'b0, scl, sda_m, sda_out, sda_oe, hs, ack;
	logic [5:0] adr = 6'h2A;
	logic [7:0] rd_data = 8'h00, nrd = 8'h00, ra, q;
	wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
	reg_req_type reg_req;
	logic [15:0] wq[$];
	int num_errors = 0, tests_run = 0, cyc = 0;
	always #10 clk = ~clk;
	// Link clock kept out of phase with clk
	initial #7 forever #16 link_clk = ~link_clk;
	i2c_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda));
	i2c_slave_host_if uut (.clk(clk), .reset(reset), .link_clk(link_clk),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.address_select_pin(sel), .adr_pins(adr),
		.force_high_speed_bit(frc), .high_speed_mode(hs),
		.reg_req(reg_req), .rd_data(rd_data));
	always @(posedge clk) begin
		cyc++;
		if (reg_req.wr === 1'b1)
			wq.push_back({reg_req.addr, reg_req.data});
		if (reg_req.rd === 1'b1) begin
			ra <= reg_req.addr;
			rd_data <= 8'hC0 + nrd;
			nrd <= nrd + 8'h01;
		end
		if (cyc == 80000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic rst();
		@(posedge clk) reset <= 1'b1;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	task automatic wb(input logic [7:0] d, input logic e);
		m.xfer(d, 1'b1, q, ack);
		`CK("ack", e, ack)
	endtask
	task automatic wr_chk(input int n, input logic [15:0] e);
		repeat (20) @(posedge clk);
		`CK("nwr", n, wq.size())
		`CK("wr", e, wq[n-1])
		wq.delete();
	endtask
	task automatic t_write();
		@(posedge clk) adr <= 6'h00;
		m.start();
		wb({A0, 1'b0}, 1'b0);
		wb(8'h12, 1'b0);
		wb(8'hA5, 1'b0);
		`CK("wr0", 16'h12A5, wq[0])
		wb(8'h3C, 1'b0);
		m.stop();
		wr_chk(2, 16'h123C);
		$display("t_write done");
	endtask
	task automatic t_read();
		m.start();
		wb({A0, 1'b0}, 1'b0);
		wb(8'h07, 1'b0);
		m.stop();
		m.start();
		wb({A0, 1'b1}, 1'b0);
		m.xfer(8'hFF, 1'b0, q, ack);
		`CK("rd0", 8'hC0, q)
		m.xfer(8'hFF, 1'b1, q, ack);
		`CK("rd1", 8'hC1, q)
		`CK("nack", 1'b1, ack)
		m.stop();
		repeat (20) @(posedge clk);
		`CK("raddr", 8'h07, ra)
		`CK("nrd", 8'h02, nrd)
		$display("t_read done");
	endtask
	task automatic t_miss();
		m.start();
		wb({A0 ^ 7'h01, 1'b0}, 1'b1);
		wb(8'h12, 1'b1);
		m.stop();
		`CK("nwr", 0, wq.size())
		$display("t_miss done");
	endtask
	task automatic t_hs();
		m.start();
		wb(8'h0B, 1'b1);
		`CK("hs", 1'b1, hs)
		m.start();
		wb({A0, 1'b0}, 1'b0);
		wb(8'h21, 1'b0);
		m.start();
		`CK("hs_sr", 1'b1, hs)
		wb({A0, 1'b0}, 1'b0);
		wb(8'h21, 1'b0);
		wb(8'h5A, 1'b0);
		m.stop();
		wr_chk(1, 16'h215A);
		`CK("hs_p", 1'b0, hs)
		$display("t_hs done");
	endtask
	task automatic t_force();
		@(posedge clk) frc <= 1'b1;
		repeat (10) @(posedge clk);
		`CK("hs_f", 1'b1, hs)
		m.start();
		wb({A0, 1'b0}, 1'b0);
		wb(8'h30, 1'b0);
		wb(8'h66, 1'b0);
		m.stop();
		wr_chk(1, 16'h3066);
		frc <= 1'b0;
		repeat (10) @(posedge clk);
		`CK("hs_nf", 1'b0, hs)
		$display("t_force done");
	endtask
	task automatic t_sel();
		@(posedge clk) sel <= 1'b1;
		adr <= 6'h15;
		rst();
		m.start();
		wb({A0, 1'b0}, 1'b1);
		m.start();
		wb(8'h2A, 1'b0);
		wb(8'h44, 1'b0);
		wb(8'h99, 1'b0);
		m.stop();
		wr_chk(1, 16'h4499);
		$display("t_sel done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		rst();
		t_write();
		t_read();
		t_miss();
		t_hs();
		t_force();
		t_sel();
		stop_test();
	end
endmodule
